// File: xvt_timing_gen.sv
module xvt_timing_gen #(
    parameter int CW = 12
) (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    // Register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // Converter buses, two pixels each
    input  wire logic [47:0] conv_a_i,
    input  wire logic [47:0] conv_b_i,
    // Panel and converter side
    output logic             hsync_o,
    output logic             vsync_o,
    output logic             de_o,
    output logic      [23:0] pixel_o,
    output logic             adc_phase_o
);

    localparam int SW = 15;

    // RULE13 line length limit
    if (CW < 11 || CW > 12) begin : g_cw_check
        $error("CW must be 11 or 12");
    end

    logic                 rst_q1;
    logic                 rst_s_n;
    logic                 run;
    logic [1:0]           fmt;
    logic                 hpol;
    logic                 vpol;
    logic                 dpol;
    logic                 path;
    logic                 ppong;
    xvt_pkg::xvt_len_t    hlen [6];
    xvt_pkg::xvt_len_t    vlen [6];
    logic [CW-1:0]        hcnt;
    logic [CW-1:0]        vcnt;
    logic [SW-1:0]        hs_b;
    logic [SW-1:0]        hbp_b;
    logic [SW-1:0]        hav_b;
    logic [SW-1:0]        hrb_b;
    logic [SW-1:0]        pixels_per_line_total;
    logic [SW-1:0]        vs_b;
    logic [SW-1:0]        vbp_b;
    logic [SW-1:0]        vav_b;
    logic [SW-1:0]        vrb_b;
    logic [SW-1:0]        lines_per_frame_total;
    logic [SW-1:0]        hc;
    logic [SW-1:0]        vc;
    logic                 h_last;
    logic                 v_last;
    logic                 h_sync;
    logic                 v_sync;
    logic                 h_act;
    logic                 v_act;
    logic [23:0]          a_px;
    logic [23:0]          b_px;

    // Reset release through two stages
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_q1  <= 1'b0;
            rst_s_n <= 1'b0;
        end else begin
            rst_q1  <= 1'b1;
            rst_s_n <= rst_q1;
        end
    end

    // Control and interval registers
    always_ff @(posedge mclk_i or negedge rst_s_n) begin
        if (!rst_s_n) begin
            run   <= xvt_pkg::CTRL_RST[xvt_pkg::CTRL_RUN];
            fmt   <= xvt_pkg::CTRL_RST[xvt_pkg::CTRL_FMT +: 2];
            hpol  <= xvt_pkg::CTRL_RST[xvt_pkg::CTRL_HPOL];
            vpol  <= xvt_pkg::CTRL_RST[xvt_pkg::CTRL_VPOL];
            dpol  <= xvt_pkg::CTRL_RST[xvt_pkg::CTRL_DPOL];
            path  <= xvt_pkg::CTRL_RST[xvt_pkg::CTRL_PATH];
            ppong <= xvt_pkg::CTRL_RST[xvt_pkg::CTRL_PPONG];
            hlen  <= xvt_pkg::PRE_H[0];
            vlen  <= xvt_pkg::PRE_V[0];
        end else if (wr_i) begin
            if (addr_i == xvt_pkg::REG_CTRL) begin
                run   <= wdata_i[xvt_pkg::CTRL_RUN];
                fmt   <= wdata_i[xvt_pkg::CTRL_FMT +: 2];
                dpol  <= wdata_i[xvt_pkg::CTRL_DPOL];
                path  <= wdata_i[xvt_pkg::CTRL_PATH];
                ppong <= wdata_i[xvt_pkg::CTRL_PPONG];
                // RULE4 RULE8 preset load
                if (wdata_i[xvt_pkg::CTRL_LOAD]) begin
                    hlen <= xvt_pkg::PRE_H[wdata_i[xvt_pkg::CTRL_FMT +: 2]];
                    vlen <= xvt_pkg::PRE_V[wdata_i[xvt_pkg::CTRL_FMT +: 2]];
                    hpol <= xvt_pkg::PRE_POS[wdata_i[xvt_pkg::CTRL_FMT +: 2]];
                    vpol <= xvt_pkg::PRE_POS[wdata_i[xvt_pkg::CTRL_FMT +: 2]];
                end else begin
                    hpol <= wdata_i[xvt_pkg::CTRL_HPOL];
                    vpol <= wdata_i[xvt_pkg::CTRL_VPOL];
                end
            end else if (addr_i == xvt_pkg::REG_H0) begin
                hlen[xvt_pkg::IV_FP] <= wdata_i[11:0];
                hlen[xvt_pkg::IV_ST] <= wdata_i[xvt_pkg::FLD_HI +: 12];
            end else if (addr_i == xvt_pkg::REG_H1) begin
                hlen[xvt_pkg::IV_BP] <= wdata_i[11:0];
                hlen[xvt_pkg::IV_LB] <= wdata_i[xvt_pkg::FLD_HI +: 12];
            end else if (addr_i == xvt_pkg::REG_H2) begin
                hlen[xvt_pkg::IV_AV] <= wdata_i[11:0];
                hlen[xvt_pkg::IV_RB] <= wdata_i[xvt_pkg::FLD_HI +: 12];
            end else if (addr_i == xvt_pkg::REG_V0) begin
                vlen[xvt_pkg::IV_FP] <= wdata_i[11:0];
                vlen[xvt_pkg::IV_ST] <= wdata_i[xvt_pkg::FLD_HI +: 12];
            end else if (addr_i == xvt_pkg::REG_V1) begin
                vlen[xvt_pkg::IV_BP] <= wdata_i[11:0];
                vlen[xvt_pkg::IV_LB] <= wdata_i[xvt_pkg::FLD_HI +: 12];
            end else if (addr_i == xvt_pkg::REG_V2) begin
                vlen[xvt_pkg::IV_AV] <= wdata_i[11:0];
                vlen[xvt_pkg::IV_RB] <= wdata_i[xvt_pkg::FLD_HI +: 12];
            end
        end
    end

    // RULE1 RULE2 interval boundaries
    always_comb begin
        hs_b  = SW'(hlen[xvt_pkg::IV_FP]);
        hbp_b = hs_b + SW'(hlen[xvt_pkg::IV_ST]);
        hav_b = hbp_b + SW'(hlen[xvt_pkg::IV_BP])
              + SW'(hlen[xvt_pkg::IV_LB]);
        hrb_b = hav_b + SW'(hlen[xvt_pkg::IV_AV]);
        pixels_per_line_total = hrb_b + SW'(hlen[xvt_pkg::IV_RB]);
        vs_b  = SW'(vlen[xvt_pkg::IV_FP]);
        vbp_b = vs_b + SW'(vlen[xvt_pkg::IV_ST]);
        vav_b = vbp_b + SW'(vlen[xvt_pkg::IV_BP])
              + SW'(vlen[xvt_pkg::IV_LB]);
        vrb_b = vav_b + SW'(vlen[xvt_pkg::IV_AV]);
        lines_per_frame_total = vrb_b + SW'(vlen[xvt_pkg::IV_RB]);
    end

    // Totals past the counter range wrap at all ones
    always_comb begin
        hc     = SW'(hcnt);
        vc     = SW'(vcnt);
        h_last = (hc + SW'(1)) >= pixels_per_line_total || (&hcnt);
        v_last = (vc + SW'(1)) >= lines_per_frame_total || (&vcnt);
        h_sync = hc >= hs_b && hc < hbp_b;
        v_sync = vc >= vs_b && vc < vbp_b;
        h_act  = hc >= hav_b && hc < hrb_b;
        v_act  = vc >= vav_b && vc < vrb_b;
    end

    // RULE16 pixel and line counters
    always_ff @(posedge mclk_i or negedge rst_s_n) begin
        if (!rst_s_n) begin
            hcnt <= '0;
            vcnt <= '0;
        end else if (!run) begin
            hcnt <= '0;
            vcnt <= '0;
        end else if (h_last) begin
            hcnt <= '0;
            vcnt <= v_last ? '0 : vcnt + 1'b1;
        end else begin
            hcnt <= hcnt + 1'b1;
        end
    end

    // RULE11 RULE12 RULE17 timing outputs
    always_ff @(posedge mclk_i or negedge rst_s_n) begin
        if (!rst_s_n) begin
            hsync_o <= ~xvt_pkg::CTRL_RST[xvt_pkg::CTRL_HPOL];
            vsync_o <= ~xvt_pkg::CTRL_RST[xvt_pkg::CTRL_VPOL];
            de_o    <= ~xvt_pkg::CTRL_RST[xvt_pkg::CTRL_DPOL];
        end else begin
            hsync_o <= (run && h_sync) ? hpol : ~hpol;
            vsync_o <= (run && v_sync) ? vpol : ~vpol;
            de_o    <= (run && h_act && v_act) ? dpol : ~dpol;
        end
    end

    // RULE15 half of each double bus
    always_comb begin
        a_px = path ? conv_a_i[47:24] : conv_a_i[23:0];
        b_px = path ? conv_b_i[47:24] : conv_b_i[23:0];
    end

    // RULE14 alternate converters, realigned each line
    always_ff @(posedge mclk_i or negedge rst_s_n) begin
        if (!rst_s_n) begin
            adc_phase_o <= 1'b0;
        end else if (!run || !ppong || h_last) begin
            adc_phase_o <= 1'b0;
        end else begin
            adc_phase_o <= ~adc_phase_o;
        end
    end

    // RULE14 RULE15 pixel path
    always_ff @(posedge mclk_i or negedge rst_s_n) begin
        if (!rst_s_n) begin
            pixel_o <= '0;
        end else begin
            pixel_o <= (ppong && adc_phase_o) ? b_px : a_px;
        end
    end

    // Read data lives one cycle only
    always_ff @(posedge mclk_i or negedge rst_s_n) begin
        if (!rst_s_n) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= '0;
            if (rd_i) begin
                if (addr_i == xvt_pkg::REG_CTRL) begin
                    rdata_o <= {23'h0, ppong, path, dpol, vpol, hpol,
                                1'b0, fmt, run};
                end else if (addr_i == xvt_pkg::REG_H0) begin
                    rdata_o <= {4'h0, hlen[1], 4'h0, hlen[0]};
                end else if (addr_i == xvt_pkg::REG_H1) begin
                    rdata_o <= {4'h0, hlen[3], 4'h0, hlen[2]};
                end else if (addr_i == xvt_pkg::REG_H2) begin
                    rdata_o <= {4'h0, hlen[5], 4'h0, hlen[4]};
                end else if (addr_i == xvt_pkg::REG_V0) begin
                    rdata_o <= {4'h0, vlen[1], 4'h0, vlen[0]};
                end else if (addr_i == xvt_pkg::REG_V1) begin
                    rdata_o <= {4'h0, vlen[3], 4'h0, vlen[2]};
                end else if (addr_i == xvt_pkg::REG_V2) begin
                    rdata_o <= {4'h0, vlen[5], 4'h0, vlen[4]};
                end else if (addr_i == xvt_pkg::REG_STAT) begin
                    rdata_o <= {16'(vcnt), 16'(hcnt)};
                end
            end
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_s_n);

    // RULE4 60 Hz load
    a_load_60hz: assert property ( // RULE4
        wr_i && addr_i == xvt_pkg::REG_CTRL && wdata_i[3] &&
        wdata_i[2:1] == 2'h0 |=> pixels_per_line_total == 15'h540 && hs_b == 15'h018 &&
        hbp_b == 15'h0a0 && !hpol && !vpol)
        else $error("60 Hz line preset wrong");

    // RULE7 85 Hz load
    a_load_85hz: assert property ( // RULE7
        wr_i && addr_i == xvt_pkg::REG_CTRL && wdata_i[3] &&
        wdata_i[2:1] == 2'h3 |=> pixels_per_line_total == 15'h560 && hs_b == 15'h030 &&
        hbp_b == 15'h090 && hpol && vpol)
        else $error("85 Hz line preset wrong");

    // RULE8 RULE3 frame preset
    a_frame_806: assert property ( // RULE8
        wr_i && addr_i == xvt_pkg::REG_CTRL && wdata_i[3] &&
        wdata_i[2:1] == 2'h1 |=> lines_per_frame_total == 15'h326 && vs_b == 15'h003 &&
        vbp_b == 15'h009 && hlen[3] == 12'h0 && vlen[5] == 12'h0)
        else $error("70 Hz frame preset wrong");

    // RULE10 frame preset
    a_frame_808: assert property ( // RULE10
        wr_i && addr_i == xvt_pkg::REG_CTRL && wdata_i[3] &&
        wdata_i[2:1] == 2'h3 |=> lines_per_frame_total == 15'h328 && vav_b == 15'h028)
        else $error("85 Hz frame preset wrong");

    // RULE11 enable excludes sync
    a_de_no_sync: assert property ( // RULE11
        de_o == $past(dpol) |-> hsync_o != $past(hpol))
        else $error("data enable overlaps hsync");

    // RULE16 counter wrap
    a_h_wrap: assert property ( // RULE16
        run && h_last |=> hcnt == '0)
        else $error("pixel counter did not wrap");

    // RULE16 line advance
    a_v_step: assert property ( // RULE16
        run && h_last && !v_last |=> vcnt == CW'($past(vcnt) + 1'b1))
        else $error("line counter did not advance");

    // RULE17 idle outputs
    a_idle_sync: assert property ( // RULE17
        !run |=> hsync_o == ~$past(hpol) && vsync_o == ~$past(vpol) &&
        de_o == ~$past(dpol))
        else $error("timing output active while stopped");

    // RULE14 phase alternation
    a_pp_toggle: assert property ( // RULE14
        run && ppong && !h_last |=> adc_phase_o != $past(adc_phase_o))
        else $error("converter phase did not alternate");

    // RULE15 low half path
    a_path_low: assert property ( // RULE15
        !ppong && !path |=> pixel_o == $past(conv_a_i[23:0]))
        else $error("wrong pixel path selected");

    // RULE5 70 Hz load
    a_load_70hz: assert property ( // RULE5
        wr_i && addr_i == xvt_pkg::REG_CTRL && wdata_i[3] &&
        wdata_i[2:1] == 2'h1 |=> pixels_per_line_total == 15'h530 && hs_b == 15'h018 &&
        hbp_b == 15'h0a0 && !hpol && !vpol)
        else $error("70 Hz line preset wrong");

    // RULE6 75 Hz load
    a_load_75hz: assert property ( // RULE6
        wr_i && addr_i == xvt_pkg::REG_CTRL && wdata_i[3] &&
        wdata_i[2:1] == 2'h2 |=> pixels_per_line_total == 15'h520 && hs_b == 15'h010 &&
        hbp_b == 15'h070 && hpol && vpol)
        else $error("75 Hz line preset wrong");

    // RULE9 frame preset
    a_frame_800: assert property ( // RULE9
        wr_i && addr_i == xvt_pkg::REG_CTRL && wdata_i[3] &&
        wdata_i[2:1] == 2'h2 |=> lines_per_frame_total == 15'h320 && vs_b == 15'h001 &&
        vbp_b == 15'h004 && vav_b == 15'h020)
        else $error("75 Hz frame preset wrong");

    // RULE12 hsync in tip
    a_hsync_tip: assert property ( // RULE12
        run && h_sync |=> hsync_o == $past(hpol))
        else $error("hsync inactive inside sync tip");

    // RULE17 vsync outside tip
    a_vsync_idle: assert property ( // RULE17
        run && !v_sync |=> vsync_o == ~$past(vpol))
        else $error("vsync active outside sync tip");

    // RULE11 enable in window
    a_de_window: assert property ( // RULE11
        run && h_act && v_act |=> de_o == $past(dpol))
        else $error("data enable missing in active window");

    a_rd_idle: assert property (
        !rd_i |=> rdata_o == 32'h0)
        else $error("read data outside read slot");

endmodule // xvt_timing_gen

// File: xvt_pkg.sv
// Operation
// RULE1: Line runs front porch, sync tip, back porch, left border, active, right.
// RULE2: Frame uses the same six intervals, counted in lines.
// RULE3: All border intervals of the listed formats are zero.
// RULE4: 60 Hz format: 24, 136, 160, 1024, total 1344, syncs low.
// RULE5: 70 Hz format: 24, 136, 144, 1024, total 1328, syncs low.
// RULE6: 75 Hz format: 16, 96, 176, 1024, total 1312, syncs high.
// RULE7: 85 Hz format: 48, 96, 208, 1024, total 1376, syncs high.
// RULE8: 60 and 70 Hz frames: 3, 6, 29, 768, total 806 lines.
// RULE9: 75 Hz frame: 1, 3, 28, 768, total 800 lines.
// RULE10: 85 Hz frame: 1, 3, 36, 768, total 808 lines.
// RULE11: Data enable only when both counters are inside active video.
// RULE12: Hsync, vsync and data enable have programmable position, width, polarity.
// RULE13: Lines of up to 4096 pixels are supported.
// RULE14: Ping-pong converters take alternate pixels at half the pixel rate.
// RULE15: Select one 24-bit pixel path from the 48-line double bus.
// RULE16: Pixel counter wraps at total minus one, advancing the line counter.
// RULE17: Syncs inactive outside sync tip; all timing outputs inactive in reset.
package xvt_pkg;

    // Register byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_H0   = 8'h04;
    localparam logic [7:0] REG_H1   = 8'h08;
    localparam logic [7:0] REG_H2   = 8'h0c;
    localparam logic [7:0] REG_V0   = 8'h10;
    localparam logic [7:0] REG_V1   = 8'h14;
    localparam logic [7:0] REG_V2   = 8'h18;
    localparam logic [7:0] REG_STAT = 8'h1c;

    // Control field positions
    localparam int CTRL_RUN   = 0;
    localparam int CTRL_FMT   = 1;
    localparam int CTRL_LOAD  = 3;
    localparam int CTRL_HPOL  = 4;
    localparam int CTRL_VPOL  = 5;
    localparam int CTRL_DPOL  = 6;
    localparam int CTRL_PATH  = 7;
    localparam int CTRL_PPONG = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0041;

    // Second field of each pair sits here
    localparam int FLD_HI = 16;

    // Interval order inside a line or frame
    localparam int IV_FP = 0;
    localparam int IV_ST = 1;
    localparam int IV_BP = 2;
    localparam int IV_LB = 3;
    localparam int IV_AV = 4;
    localparam int IV_RB = 5;

    typedef logic [11:0] xvt_len_t;

    // RULE1 RULE3 RULE4 RULE5 RULE6 RULE7 horizontal presets
    localparam xvt_len_t PRE_H [4][6] = '{
        '{12'h018, 12'h088, 12'h0a0, 12'h000, 12'h400, 12'h000},
        '{12'h018, 12'h088, 12'h090, 12'h000, 12'h400, 12'h000},
        '{12'h010, 12'h060, 12'h0b0, 12'h000, 12'h400, 12'h000},
        '{12'h030, 12'h060, 12'h0d0, 12'h000, 12'h400, 12'h000}};
    // RULE2 RULE3 RULE8 RULE9 RULE10 vertical presets
    localparam xvt_len_t PRE_V [4][6] = '{
        '{12'h003, 12'h006, 12'h01d, 12'h000, 12'h300, 12'h000},
        '{12'h003, 12'h006, 12'h01d, 12'h000, 12'h300, 12'h000},
        '{12'h001, 12'h003, 12'h01c, 12'h000, 12'h300, 12'h000},
        '{12'h001, 12'h003, 12'h024, 12'h000, 12'h300, 12'h000}};
    // Sync polarity per format, 1 is active high
    localparam logic [3:0] PRE_POS = 4'hc;

endpackage

// File: xvt_panel_model.sv
module xvt_panel_model (
    // Clock
    input  wire logic       mclk_i,
    // Timing seen by the panel
    input  wire logic       hsync_i,
    input  wire logic       vsync_i,
    input  wire logic       de_i,
    // Active levels expected: de, vsync, hsync
    input  wire logic [2:0] pol_i,
    // Measured figures, in pixel clocks except de_lines_o, which counts lines
    output int              hs_width_o,
    output int              line_len_o,
    output int              de_run_o,
    output int              de_lines_o,
    output int              vs_width_o,
    output int              hs_to_de_o,
    output int              vs_to_de_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic hs;
    logic vs;
    logic d;
    logic hs_q = 1'b0;
    logic vs_q = 1'b0;
    logic d_q  = 1'b0;
    int   hc, vc, hw, vw, dr, nd;

    // Unknown levels read as inactive, as a real panel would see noise
    assign hs = (hsync_i === pol_i[0]);
    assign vs = (vsync_i === pol_i[1]);
    assign d  = (de_i === pol_i[2]);

    always @(posedge mclk_i) begin
        hs_q <= hs;
        vs_q <= vs;
        d_q  <= d;
        hc   <= (hs && !hs_q) ? 1 : hc + 1;
        vc   <= (vs && !vs_q) ? 1 : vc + 1;
        hw   <= hs ? hw + 1 : 0;
        vw   <= vs ? vw + 1 : 0;
        dr   <= d ? dr + 1 : 0;
        if (hs && !hs_q)
            line_len_o <= hc;
        if (!hs && hs_q)
            hs_width_o <= hw;
        if (!vs && vs_q)
            vs_width_o <= vw;
        if (!d && d_q)
            de_run_o <= dr;
        if (vs && !vs_q) begin
            de_lines_o <= nd;
            nd <= 0;
        end else if (d && !d_q) begin
            nd <= nd + 1;
        end
        if (d && !d_q) begin
            hs_to_de_o <= hc;
            if (nd == 0)
                vs_to_de_o <= vc;
        end
    end
endmodule // xvt_panel_model

// File: test_xvt_timing_gen.sv
module test_xvt_timing_gen;
    timeunit 1ns;
    timeprecision 100ps;

    logic        mclk_i  = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  addr    = 8'h00;
    logic [31:0] wdata   = 32'h0;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic [47:0] conv_a  = 48'habcdef_123456;
    logic [47:0] conv_b  = 48'h654321_fedcba;
    logic [2:0]  pol     = 3'b100;
    logic [31:0] rdata_o;
    logic [23:0] pixel_o;
    logic        hsync_o, vsync_o, de_o, adc_phase_o, ph;
    int          hw, ll, dr, dl, vw, hd, vd, ones;
    int          failures  = 0;
    int          cmp_count = 0;
    logic [11:0] hp [4][4] = '{'{12'h018, 12'h088, 12'h0a0, 12'h400},
        '{12'h018, 12'h088, 12'h090, 12'h400},
        '{12'h010, 12'h060, 12'h0b0, 12'h400},
        '{12'h030, 12'h060, 12'h0d0, 12'h400}};
    logic [11:0] vp [4][3] = '{'{12'h003, 12'h006, 12'h01d},
        '{12'h003, 12'h006, 12'h01d}, '{12'h001, 12'h003, 12'h01c},
        '{12'h001, 12'h003, 12'h024}};

    always #12.5 mclk_i = ~mclk_i;

    xvt_timing_gen u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata_o),
        .conv_a_i(conv_a), .conv_b_i(conv_b), .hsync_o(hsync_o),
        .vsync_o(vsync_o), .de_o(de_o), .pixel_o(pixel_o),
        .adc_phase_o(adc_phase_o));

    xvt_panel_model u_panel (.mclk_i(mclk_i), .hsync_i(hsync_o),
        .vsync_i(vsync_o), .de_i(de_o), .pol_i(pol), .hs_width_o(hw),
        .line_len_o(ll), .de_run_o(dr), .de_lines_o(dl), .vs_width_o(vw),
        .hs_to_de_o(hd), .vs_to_de_o(vd));

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk_i);
        wr    <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk_i);
        rd   <= 1'b0;
        #1 chk($sformatf("register %h", a), e, rdata_o);
    endtask

    task automatic ax(input logic [7:0] b, input logic [11:0] a0, a1, a2,
                      a3, a4, a5);
        wreg(b, {4'h0, a1, 4'h0, a0});
        wreg(b + 8'h04, {4'h0, a3, 4'h0, a2});
        wreg(b + 8'h08, {4'h0, a5, 4'h0, a4});
    endtask

    // Small test format: 17 pixels by 9 lines
    task automatic meas(input int w);
        repeat (w) @(posedge mclk_i);
        chk("hsync width", 32'h3, hw);
        chk("line length", 32'h11, ll);
        chk("de run", 32'h5, dr);
        chk("de lines", 32'h3, dl);
        chk("vsync width", 32'h22, vw);
        chk("hsync to de", 32'h8, hd);
        chk("vsync to de", 32'h4e, vd);
    endtask

    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge mclk_i);
        failures++;
        end_sim;
    end

    initial begin
        repeat (10) @(posedge mclk_i);
        #1 chk("reset outputs", 32'h0c00_0000,
            {hsync_o, vsync_o, de_o, adc_phase_o, pixel_o});
        @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rreg(xvt_pkg::REG_CTRL, 32'h0000_0041);
        rreg(8'h20, 32'h0);
        wreg(8'h24, 32'hffff_ffff);
        rreg(xvt_pkg::REG_CTRL, 32'h0000_0041);
        repeat (2800) @(posedge mclk_i);
        chk("line 60 Hz", 32'h540, ll);
        chk("hsync 60 Hz", 32'h88, hw);
        for (int f = 0; f < 4; f++) begin
            // Written sync polarity bits must lose to the preset
            wreg(xvt_pkg::REG_CTRL, 32'h48 | (f << 1) | (f < 2 ? 32'h30 : 0));
            rreg(xvt_pkg::REG_CTRL, 32'h40 | (f << 1) | (f > 1 ? 32'h30 : 0));
            rreg(xvt_pkg::REG_H0, {4'h0, hp[f][1], 4'h0, hp[f][0]});
            rreg(xvt_pkg::REG_H1, {20'h0, hp[f][2]});
            rreg(xvt_pkg::REG_H2, {20'h0, hp[f][3]});
            rreg(xvt_pkg::REG_V0, {4'h0, vp[f][1], 4'h0, vp[f][0]});
            rreg(xvt_pkg::REG_V1, {20'h0, vp[f][2]});
            rreg(xvt_pkg::REG_V2, 32'h0000_0300);
        end
        rreg(xvt_pkg::REG_STAT, 32'h0);
        ax(xvt_pkg::REG_H0, 12'h2, 12'h3, 12'h4, 12'h1, 12'h5, 12'h2);
        ax(xvt_pkg::REG_V0, 12'h1, 12'h2, 12'h1, 12'h1, 12'h3, 12'h1);
        pol <= 3'b111;
        wreg(xvt_pkg::REG_CTRL, 32'h71);
        meas(500);
        pol <= 3'b000;
        wreg(xvt_pkg::REG_CTRL, 32'h01);
        meas(500);
        wreg(xvt_pkg::REG_CTRL, 32'h101);
        ones = 0;
        @(posedge mclk_i);
        #1 ph = adc_phase_o;
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk_i);
            #1 chk("ping-pong pixel", ph ? conv_b[23:0] : conv_a[23:0], pixel_o);
            ones += ph;
            ph = adc_phase_o;
        end
        chk("phase toggles", 32'h1, ones > 2);
        wreg(xvt_pkg::REG_CTRL, 32'h81);
        repeat (2) @(posedge mclk_i);
        #1 chk("upper path", {conv_a[47:24], 1'b0}, {pixel_o, adc_phase_o});
        ax(xvt_pkg::REG_H0, 12'h1, 12'h1, 12'h1, 12'h0, 12'hffd, 12'h0);
        repeat (8300) @(posedge mclk_i);
        chk("longest line", 32'h1000, ll);
        end_sim;
    end
endmodule // test_xvt_timing_gen
